// ### core/scr_defs.svh
// register offsets, field positions, write masks and reset values
// assumes byte-wide registers reached over the serial management bus
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH
`define SCR_A_GPIN 8'h05
`define SCR_A_GPOUT 8'h06
`define SCR_A_EMPH 8'h20
`define SCR_A_CFG 8'h21
`define SCR_A_UNLK 8'h22
`define SCR_A_CKD 8'h24
`define SCR_RST_VAL 8'h00
`define SCR_M_GP 8'h07
`define SCR_M_EMPH 8'h07
`define SCR_M_CFG 8'hdf
`define SCR_M_UNLK 8'h1f
`define SCR_M_CKD 8'h80
`define SCR_B_EMPH_OVR 2
`define SCR_B_NRZI 7
`define SCR_B_DVDIS 6
`define SCR_B_SCR 4
`define SCR_B_BYP 3
`define SCR_B_TRN 2
`define SCR_U_CFG 0
`define SCR_U_TRN 1
`define SCR_U_BYP 2
`define SCR_U_SCR 3
`define SCR_U_NRZI 4
`define SCR_B_CKD_BYP 7
`define SCR_DEV_ADDR 7'h5a
`endif

// ### core/scr_pkg.sv
// types shared by the configuration register bank
// assumes scr_defs.svh supplies all numeric constants except the state codes defined here
package scr_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ACK_A = 4'h3,
    ST_REG = 4'h2,
    ST_ACK_R = 4'h6,
    ST_WDATA = 4'h7,
    ST_ACK_W = 4'h5,
    ST_RDATA = 4'h4,
    ST_RACK = 4'hc
  } scr_state_e;
endpackage

// ### core/scr_regs.sv
// serial-management slave plus aux pin, emphasis and link configuration registers
// assumes all pins synchronous to mclk; sda is open drain, resolved outside
// How it works
// - input register bits 2:0 show sampled aux pin levels, read only, reset zero
// - output register bits 2:0 always drive the three aux pin levels; aux_drive_en sets the enables
// - two-bit emphasis level applies only while bit 2 override set, else pins
// - config bit 7 enables nrzi coding when its unlock bit is set
// - config bit 6 suppresses the payload valid marker on the link
// - config bit 4 enables the scrambler only while its unlock bit set
// - config bit 3 bypasses the balance encoder only while unlocked
// - config bit 2 enables training sequence only while unlocked
// - config bits 1:0 are active-low remote sense and encoder enables, pins otherwise
// - unlock bit 0 hands config bits 1:0 from pins to register
// - unlock bits 4,3,2,1 free config bits 7,4,3,2 respectively
// - clock delay bit 7 zero inserts input delay, one bypasses it
`timescale 1ns/1ps
`include "scr_defs.svh"
module scr_regs (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic smb_cs,
  input wire logic smb_scl,
  input wire logic smb_sda_i,
  output logic smb_sda_o,
  output logic smb_sda_oe,
  input wire logic aux_pin_a_i,
  input wire logic aux_pin_b_i,
  input wire logic aux_pin_c_i,
  output logic aux_pin_a_o,
  output logic aux_pin_b_o,
  output logic aux_pin_c_o,
  output logic aux_pin_a_oe,
  output logic aux_pin_b_oe,
  output logic aux_pin_c_oe,
  input wire logic [2:0] aux_drive_en,
  input wire logic [1:0] emph_pin,
  input wire logic nrzi_pin,
  input wire logic scrambler_pin,
  input wire logic encoder_bypass_pin,
  input wire logic training_pin,
  input wire logic [1:0] config_pin,
  output logic [1:0] emph_level,
  output logic nrzi_en,
  output logic payload_valid_marker_dis,
  output logic scrambler_en,
  output logic balance_encoder_bypass,
  output logic training_en,
  output logic remote_sense_n,
  output logic balance_encoder_en_n,
  output logic clock_delay_bypass
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  scr_pkg::scr_state_e state_ff, nxt_state;
  logic [2:0] cnt_ff, nxt_cnt;
  logic full_ff, nxt_full;
  logic [7:0] sh_ff, nxt_sh;
  logic [7:0] ptr_ff, nxt_ptr;
  logic [7:0] tx_ff, nxt_tx;
  logic rw_ff, nxt_rw;
  logic ack_ok_ff, nxt_ack_ok;
  logic scl_q_ff, nxt_scl_q;
  logic sda_q_ff, nxt_sda_q;
  logic sda_oe_ff, nxt_sda_oe;
  logic wr_stb;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  logic [7:0] gp_input_levels_ff, nxt_gp_input_levels;
  logic [7:0] gp_output_levels_ff, nxt_gp_output_levels;
  logic [7:0] emph_ff, nxt_emph;
  logic [7:0] cfg_ff, nxt_cfg;
  logic [7:0] unlk_ff, nxt_unlk;
  logic [7:0] ckd_ff, nxt_ckd;
  logic [9:0] eff_ff, nxt_eff;
  logic [2:0] aux_i, aux_o, aux_oe;

  assign aux_i = {aux_pin_c_i, aux_pin_b_i, aux_pin_a_i};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_aux
      assign aux_o[gi] = gp_output_levels_ff[gi];
      assign aux_oe[gi] = aux_drive_en[gi];
    end
  endgenerate
  assign {aux_pin_c_o, aux_pin_b_o, aux_pin_a_o} = aux_o;
  assign {aux_pin_c_oe, aux_pin_b_oe, aux_pin_a_oe} = aux_oe;

  function automatic logic [7:0] rd_val(input logic [7:0] a);
    case (a)
      `SCR_A_GPIN: rd_val = gp_input_levels_ff & `SCR_M_GP;
      `SCR_A_GPOUT: rd_val = gp_output_levels_ff;
      `SCR_A_EMPH: rd_val = emph_ff;
      `SCR_A_CFG: rd_val = cfg_ff;
      `SCR_A_UNLK: rd_val = unlk_ff;
      `SCR_A_CKD: rd_val = ckd_ff;
      default: rd_val = 8'h00;
    endcase
  endfunction

  assign scl_rise = smb_scl & ~scl_q_ff;
  assign scl_fall = ~smb_scl & scl_q_ff;
  assign bus_start = smb_scl & scl_q_ff & sda_q_ff & ~smb_sda_i;
  assign bus_stop = smb_scl & scl_q_ff & ~sda_q_ff & smb_sda_i;
  assign smb_sda_o = 1'b0;
  assign smb_sda_oe = sda_oe_ff;

  // bus slave: bits sampled on rising scl, state moves on falling scl
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_full = full_ff;
    nxt_sh = sh_ff;
    nxt_ptr = ptr_ff;
    nxt_tx = tx_ff;
    nxt_rw = rw_ff;
    nxt_ack_ok = ack_ok_ff;
    nxt_scl_q = smb_scl;
    nxt_sda_q = smb_sda_i;
    wr_stb = 1'b0;
    if (scl_rise) begin
      nxt_sh = {sh_ff[6:0], smb_sda_i};
      nxt_cnt = cnt_ff + 3'h1;
      nxt_full = (cnt_ff == 3'h7);
      if (state_ff == scr_pkg::ST_RACK) begin
        nxt_ack_ok = ~smb_sda_i;
      end
    end
    if (scl_fall) begin
      case (state_ff)
        scr_pkg::ST_ADDR: begin
          if (full_ff) begin
            nxt_rw = sh_ff[0];
            nxt_state = (sh_ff[7:1] == `SCR_DEV_ADDR) ? scr_pkg::ST_ACK_A : scr_pkg::ST_IDLE;
          end
        end
        scr_pkg::ST_ACK_A: begin
          nxt_cnt = 3'h0;
          nxt_full = 1'b0;
          if (rw_ff) begin
            nxt_state = scr_pkg::ST_RDATA;
            nxt_tx = rd_val(ptr_ff);
          end else begin
            nxt_state = scr_pkg::ST_REG;
          end
        end
        scr_pkg::ST_REG: begin
          if (full_ff) begin
            nxt_ptr = sh_ff;
            nxt_state = scr_pkg::ST_ACK_R;
          end
        end
        scr_pkg::ST_ACK_R: begin
          nxt_cnt = 3'h0;
          nxt_full = 1'b0;
          nxt_state = scr_pkg::ST_WDATA;
        end
        scr_pkg::ST_WDATA: begin
          if (full_ff) begin
            wr_stb = 1'b1;
            nxt_state = scr_pkg::ST_ACK_W;
          end
        end
        scr_pkg::ST_ACK_W: begin
          nxt_cnt = 3'h0;
          nxt_full = 1'b0;
          nxt_ptr = ptr_ff + 8'h01;
          nxt_state = scr_pkg::ST_WDATA;
        end
        scr_pkg::ST_RDATA: begin
          if (full_ff) begin
            nxt_ptr = ptr_ff + 8'h01;
            nxt_state = scr_pkg::ST_RACK;
          end else begin
            nxt_tx = {tx_ff[6:0], 1'b0};
          end
        end
        scr_pkg::ST_RACK: begin
          nxt_cnt = 3'h0;
          nxt_full = 1'b0;
          if (ack_ok_ff) begin
            nxt_state = scr_pkg::ST_RDATA;
            nxt_tx = rd_val(ptr_ff);
          end else begin
            nxt_state = scr_pkg::ST_IDLE;
          end
        end
        scr_pkg::ST_IDLE: begin
          nxt_state = scr_pkg::ST_IDLE;
        end
        default: nxt_state = scr_pkg::ST_IDLE;
      endcase
    end
    if (bus_start) begin
      nxt_state = scr_pkg::ST_ADDR;
      nxt_cnt = 3'h0;
      nxt_full = 1'b0;
    end
    if (bus_stop || !smb_cs) begin
      nxt_state = scr_pkg::ST_IDLE;
    end
    case (nxt_state)
      scr_pkg::ST_ACK_A, scr_pkg::ST_ACK_R, scr_pkg::ST_ACK_W: nxt_sda_oe = 1'b1;
      scr_pkg::ST_RDATA: nxt_sda_oe = ~nxt_tx[7];
      default: nxt_sda_oe = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_ff <= scr_pkg::ST_IDLE;
      cnt_ff <= 3'h0;
      full_ff <= 1'b0;
      sh_ff <= 8'h00;
      ptr_ff <= 8'h00;
      tx_ff <= 8'h00;
      rw_ff <= 1'b0;
      ack_ok_ff <= 1'b0;
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      sda_oe_ff <= 1'b0;
    end else if (ce) begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      full_ff <= nxt_full;
      sh_ff <= nxt_sh;
      ptr_ff <= nxt_ptr;
      tx_ff <= nxt_tx;
      rw_ff <= nxt_rw;
      ack_ok_ff <= nxt_ack_ok;
      scl_q_ff <= nxt_scl_q;
      sda_q_ff <= nxt_sda_q;
      sda_oe_ff <= nxt_sda_oe;
    end
  end

  // register bank and effective configuration
  always_comb begin
    nxt_gp_input_levels = {5'h00, aux_i};
    nxt_gp_output_levels = gp_output_levels_ff;
    nxt_emph = emph_ff;
    nxt_cfg = cfg_ff;
    nxt_unlk = unlk_ff;
    nxt_ckd = ckd_ff;
    if (wr_stb) begin
      case (ptr_ff)
        `SCR_A_GPOUT: nxt_gp_output_levels = sh_ff & `SCR_M_GP;
        `SCR_A_EMPH: nxt_emph = sh_ff & `SCR_M_EMPH;
        `SCR_A_CFG: nxt_cfg = sh_ff & `SCR_M_CFG;
        `SCR_A_UNLK: nxt_unlk = sh_ff & `SCR_M_UNLK;
        `SCR_A_CKD: nxt_ckd = sh_ff & `SCR_M_CKD;
        default: nxt_gp_output_levels = gp_output_levels_ff;
      endcase
    end
    nxt_eff[1:0] = emph_ff[`SCR_B_EMPH_OVR] ? emph_ff[1:0] : emph_pin;
    nxt_eff[2] = unlk_ff[`SCR_U_NRZI] ? cfg_ff[`SCR_B_NRZI] : nrzi_pin;
    nxt_eff[3] = cfg_ff[`SCR_B_DVDIS];
    nxt_eff[4] = unlk_ff[`SCR_U_SCR] ? cfg_ff[`SCR_B_SCR] : scrambler_pin;
    nxt_eff[5] = unlk_ff[`SCR_U_BYP] ? cfg_ff[`SCR_B_BYP] : encoder_bypass_pin;
    nxt_eff[6] = unlk_ff[`SCR_U_TRN] ? cfg_ff[`SCR_B_TRN] : training_pin;
    nxt_eff[8:7] = unlk_ff[`SCR_U_CFG] ? cfg_ff[1:0] : config_pin;
    nxt_eff[9] = ckd_ff[`SCR_B_CKD_BYP];
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      gp_input_levels_ff <= `SCR_RST_VAL;
      gp_output_levels_ff <= `SCR_RST_VAL;
      emph_ff <= `SCR_RST_VAL;
      cfg_ff <= `SCR_RST_VAL;
      unlk_ff <= `SCR_RST_VAL;
      ckd_ff <= `SCR_RST_VAL;
      eff_ff <= 10'h000;
    end else if (ce) begin
      gp_input_levels_ff <= nxt_gp_input_levels;
      gp_output_levels_ff <= nxt_gp_output_levels;
      emph_ff <= nxt_emph;
      cfg_ff <= nxt_cfg;
      unlk_ff <= nxt_unlk;
      ckd_ff <= nxt_ckd;
      eff_ff <= nxt_eff;
    end
  end

  assign emph_level = eff_ff[1:0];
  assign nrzi_en = eff_ff[2];
  assign payload_valid_marker_dis = eff_ff[3];
  assign scrambler_en = eff_ff[4];
  assign balance_encoder_bypass = eff_ff[5];
  assign training_en = eff_ff[6];
  assign {remote_sense_n, balance_encoder_en_n} = eff_ff[8:7];
  assign clock_delay_bypass = eff_ff[9];

  a_gpin_sample: assert property (ce |=> gp_input_levels_ff[2:0] == $past(aux_i))
    else $error("aux input register not tracking pins");
  a_gpout_write: assert property (ce && wr_stb && ptr_ff == `SCR_A_GPOUT |=> aux_o == $past(sh_ff[2:0]))
    else $error("aux output write not reaching pins");
  a_emph_sel: assert property (ce |=> emph_level ==
      ($past(emph_ff[`SCR_B_EMPH_OVR]) ? $past(emph_ff[1:0]) : $past(emph_pin)))
    else $error("emphasis level wrong source");
  a_nrzi_gate: assert property (ce && !unlk_ff[`SCR_U_NRZI] |=> nrzi_en == $past(nrzi_pin))
    else $error("nrzi taken from register while locked");
  a_dv_disable: assert property (ce && cfg_ff[`SCR_B_DVDIS] |=> payload_valid_marker_dis)
    else $error("payload valid marker not suppressed");
  a_scr_gate: assert property (ce && unlk_ff[`SCR_U_SCR] |=> scrambler_en == $past(cfg_ff[`SCR_B_SCR]))
    else $error("scrambler ignores unlocked register");
  a_byp_gate: assert property (ce && !unlk_ff[`SCR_U_BYP] |=> balance_encoder_bypass == $past(encoder_bypass_pin))
    else $error("encoder bypass not from pin while locked");
  a_trn_gate: assert property (ce && unlk_ff[`SCR_U_TRN] |=> training_en == $past(cfg_ff[`SCR_B_TRN]))
    else $error("training enable ignores unlocked register");
  a_cfg_field: assert property (ce |=>
      {remote_sense_n, balance_encoder_en_n} == ($past(unlk_ff[0]) ? $past(cfg_ff[1:0]) : $past(config_pin)))
    else $error("config field wrong source");
  a_cfg_unlock: assert property (ce && unlk_ff[`SCR_U_NRZI] |=> nrzi_en == $past(cfg_ff[`SCR_B_NRZI]))
    else $error("nrzi unlock not honoured");
  a_ckd_bypass: assert property (ce |=> clock_delay_bypass == $past(ckd_ff[`SCR_B_CKD_BYP]))
    else $error("clock delay bypass mismatch");
  a_rsvd_zero: assert property (ce && scl_fall && state_ff == scr_pkg::ST_ACK_A && rw_ff
      && ptr_ff == 8'h23 |=> tx_ff == 8'h00)
    else $error("reserved address reads nonzero");
  a_rsvd_cfg5: assert property (cfg_ff[5] == 1'b0 && unlk_ff[7:5] == 3'h0)
    else $error("reserved bit stored");
  a_rsn_src: assert property (ce && unlk_ff[0] |=> remote_sense_n == $past(cfg_ff[1]))
    else $error("remote sense not from register");
endmodule

// ### sim/scr_host.sv
// bus master model for the configuration register bank
// assumes the bench resolves sda as a pulled-up wired-and of both drivers
`timescale 1ns/1ps
`include "scr_defs.svh"
module scr_host (
  input wire logic mclk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // also serves as repeated start
  task automatic start();
    sda_pull = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_pull = 1'b1;
    tick(4);
    scl = 1'b0;
    tick(2);
  endtask
  task automatic stop();
    sda_pull = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_pull = 1'b0;
    tick(4);
  endtask
  task automatic put_bit(input logic b);
    sda_pull = ~b;
    tick(2);
    scl = 1'b1;
    tick(4);
    scl = 1'b0;
    tick(2);
  endtask
  task automatic get_bit(output logic b);
    sda_pull = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(2);
    b = sda;
    tick(2);
    scl = 1'b0;
    tick(2);
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(b);
    ack = ~b;
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] ra, d, output logic ack);
    logic a0, a1, a2;
    start();
    put_byte({dev, 1'b0}, a0);
    put_byte(ra, a1);
    put_byte(d, a2);
    stop();
    ack = a0 & a1 & a2;
  endtask
  task automatic rd(input logic [7:0] ra, output logic [7:0] d, output logic ack);
    logic a0, a1, a2;
    start();
    put_byte({`SCR_DEV_ADDR, 1'b0}, a0);
    put_byte(ra, a1);
    start();
    put_byte({`SCR_DEV_ADDR, 1'b1}, a2);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    // nack ends the read
    put_bit(1'b1);
    stop();
    ack = a0 & a1 & a2;
  endtask
  // two-byte write, then read back with master ack between bytes
  task automatic burst(input logic [7:0] ra, d0, d1, output logic [15:0] q, output logic ack);
    logic [6:0] a;
    start();
    put_byte({`SCR_DEV_ADDR, 1'b0}, a[0]);
    put_byte(ra, a[1]);
    put_byte(d0, a[2]);
    put_byte(d1, a[3]);
    start();
    put_byte({`SCR_DEV_ADDR, 1'b0}, a[4]);
    put_byte(ra, a[5]);
    start();
    put_byte({`SCR_DEV_ADDR, 1'b1}, a[6]);
    for (int i = 15; i >= 0; i--) begin
      get_bit(q[i]);
      if (i == 8)
        put_bit(1'b0);
    end
    put_bit(1'b1);
    stop();
    ack = &a;
  endtask
endmodule

// ### sim/tb_top.sv
// self-checking bench for the configuration register bank
// assumes scr_host as bus master and scr_defs.svh on the include path
`timescale 1ns/1ps
`include "scr_defs.svh"
module tb_top;
  logic mclk, rst, ce, smb_cs, scl, host_pull, sda_o, sda_oe, a;
  logic [2:0] aux_i, aux_o, aux_oe, drive_en;
  logic [7:0] pins, v, d;
  logic [15:0] q;
  logic [7:0] sh [9];
  wire [9:0] eff;
  wire sda;
  int error_cnt, checks_done, cyc;
  logic [7:0] ad [9] = '{8'h05, 8'h06, 8'h20, 8'h21, 8'h22, 8'h24, 8'h07, 8'h23, 8'h25};
  logic [7:0] mk [9] = '{8'h00, 8'h07, 8'h07, 8'hdf, 8'h1f, 8'h80, 8'h00, 8'h00, 8'h00};
  assign sda = ~(host_pull | sda_oe);
  scr_host host_u (.mclk(mclk), .sda(sda), .scl(scl), .sda_pull(host_pull));
  scr_regs dut_u (.mclk(mclk), .rst(rst), .ce(ce), .smb_cs(smb_cs), .smb_scl(scl), .smb_sda_i(sda),
    .smb_sda_o(sda_o), .smb_sda_oe(sda_oe), .aux_pin_a_i(aux_i[0]), .aux_pin_b_i(aux_i[1]),
    .aux_pin_c_i(aux_i[2]), .aux_pin_a_o(aux_o[0]), .aux_pin_b_o(aux_o[1]), .aux_pin_c_o(aux_o[2]),
    .aux_pin_a_oe(aux_oe[0]), .aux_pin_b_oe(aux_oe[1]), .aux_pin_c_oe(aux_oe[2]),
    .aux_drive_en(drive_en), .emph_pin(pins[7:6]), .nrzi_pin(pins[5]), .scrambler_pin(pins[4]),
    .encoder_bypass_pin(pins[3]), .training_pin(pins[2]), .config_pin(pins[1:0]),
    .emph_level(eff[9:8]), .nrzi_en(eff[7]), .payload_valid_marker_dis(eff[6]), .scrambler_en(eff[5]),
    .balance_encoder_bypass(eff[4]), .training_en(eff[3]), .remote_sense_n(eff[2]),
    .balance_encoder_en_n(eff[1]), .clock_delay_bypass(eff[0]));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  function automatic logic [9:0] exp_eff(input logic [7:0] em, cf, un, ck, pn);
    exp_eff[9:8] = em[2] ? em[1:0] : pn[7:6];
    exp_eff[7] = un[4] ? cf[7] : pn[5];
    exp_eff[6] = cf[6];
    exp_eff[5] = un[3] ? cf[4] : pn[4];
    exp_eff[4] = un[2] ? cf[3] : pn[3];
    exp_eff[3] = un[1] ? cf[2] : pn[2];
    exp_eff[2:1] = un[0] ? cf[1:0] : pn[1:0];
    exp_eff[0] = ck[7];
  endfunction
  task automatic chk(input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    smb_cs = 1'b1;
    aux_i = 3'h5;
    drive_en = 3'h0;
    pins = 8'h00;
    void'($urandom(32'h20e10c6c));
    repeat (16) @(posedge mclk);
    #1;
    chk(16'(eff), 16'h0000);
    rst = 1'b0;
    for (int i = 0; i < 9; i++) begin
      host_u.rd(ad[i], d, a);
      chk(16'(d), (i == 0) ? 16'(aux_i) : 16'h0000);
      sh[i] = 8'h00;
    end
    $display("test reset_values done");
    for (int j = 0; j < 6; j++) begin
      pins = 8'($urandom);
      aux_i = 3'($urandom);
      drive_en = 3'($urandom);
      for (int i = 0; i < 9; i++) begin
        v = (j == 0) ? 8'hff : (j == 1) ? 8'h00 : 8'($urandom);
        if (i == 2 && j > 1)
          v[2:0] = {1'b1, 2'(j)};
        host_u.wr(`SCR_DEV_ADDR, ad[i], v, a);
        chk(16'(a), 16'h0001);
        sh[i] = v & mk[i];
        host_u.rd(ad[i], d, a);
        chk(16'(d), (i == 0) ? 16'(aux_i) : 16'(sh[i]));
      end
      host_u.tick(3);
      chk(16'(eff), 16'(exp_eff(sh[2], sh[3], sh[4], sh[5], pins)));
      chk(16'(aux_o), 16'(sh[1][2:0]));
      chk(16'(aux_oe), 16'(drive_en));
      $display("test pass %0d done", j);
    end
    ce = 1'b0;
    v = pins;
    pins = ~v;
    host_u.tick(3);
    chk(16'(eff), 16'(exp_eff(sh[2], sh[3], sh[4], sh[5], v)));
    ce = 1'b1;
    host_u.tick(3);
    chk(16'(eff), 16'(exp_eff(sh[2], sh[3], sh[4], sh[5], pins)));
    chk(16'({sda_o, sda_oe}), 16'h0000);
    $display("test clock_enable done");
    v = 8'($urandom);
    host_u.burst(8'h05, ~v, v, q, a);
    chk(16'(a), 16'h0001);
    sh[1] = v & 8'h07;
    chk(q, {5'h00, aux_i, sh[1]});
    chk(16'(aux_o), 16'(sh[1][2:0]));
    $display("test burst done");
    smb_cs = 1'b0;
    host_u.wr(`SCR_DEV_ADDR, 8'h06, ~sh[1], a);
    smb_cs = 1'b1;
    chk(16'(a), 16'h0000);
    $display("test deselect done");
    host_u.wr(`SCR_DEV_ADDR + 7'h01, 8'h06, 8'h02, a);
    chk(16'(a), 16'h0000);
    host_u.rd(8'h06, d, a);
    chk(16'(d), 16'(sh[1]));
    $display("test foreign_address done");
    results();
  end
endmodule
